/* File: tiw_far_side.sv */
// Purpose: model of the pins and core that face the irq/wake block
// Assumes: one clock; pins idle high through a pull-up
// Notes: levels stay until the bench changes them
// ------------------------------------------------------------
// far side model
// ------------------------------------------------------------
module tiw_far_side (
    input wire logic clk_sys, // system clock
    output logic ext_irq_pin_zero, // pin 0 level
    output logic ext_irq_pin_one, // pin 1 level
    output logic [7:0] vector_ack, // vector entry pulses
    output logic sleep_exec // sleep instruction pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        ext_irq_pin_zero = 1'b1;
        ext_irq_pin_one = 1'b1;
        vector_ack = 8'h00;
        sleep_exec = 1'b0;
    end
    // a level is held until changed, so a low level outlasts any instruction
    task automatic pin(input int k, input logic v);
        @(posedge clk_sys);
        if (k == 0)
            ext_irq_pin_zero <= v;
        else
            ext_irq_pin_one <= v;
    endtask : pin
    task automatic ack(input int b);
        @(posedge clk_sys);
        vector_ack <= 8'h01 << b;
        @(posedge clk_sys);
        vector_ack <= 8'h00;
    endtask : ack
    task automatic sleep_cmd();
        @(posedge clk_sys);
        sleep_exec <= 1'b1;
        @(posedge clk_sys);
        sleep_exec <= 1'b0;
    endtask : sleep_cmd
endmodule : tiw_far_side

/* File: tiw_irq_wake.sv */
// Purpose: timer interrupt flags, two external pins, sleep entry and wake
// Assumes: pins asynchronous; core signals on clk_sys
// Notes: flags are set-wins over clear; registers are never touched by sleep
module tiw_irq_wake (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped
    input wire logic [15:0] wide_count, // 16-bit timer count
    input wire logic [7:0] narrow_count, // 8-bit timer count
    input wire logic capture_strobe, // input capture event
    input wire logic updown_dir, // up/down mode: 1 while counting down
    input wire logic ext_irq_pin_zero, // external pin 0
    input wire logic ext_irq_pin_one, // external pin 1
    input wire logic [7:0] vector_ack, // core enters vector, one-hot by flag bit
    input wire logic sleep_exec, // core executes sleep instruction
    output logic [7:0] irq_req, // per-source request, flag positions, pins 6/7
    output logic core_sleep, // core is halted
    output logic [1:0] sleep_mode, // mode in force while asleep
    output logic wake_pulse // one-cycle wake to core
);
    // ------------------------------------------------------------
    // pin synchronisers (three stages, second and third agree)
    // ------------------------------------------------------------
    logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_s1_d, pin_s2_d, pin_s3_d;
    logic [1:0] pin_lvl_q, pin_lvl_d, pin_prev_q, pin_prev_d;
    always_comb
    begin
        pin_s1_d = {ext_irq_pin_one, ext_irq_pin_zero};
        pin_s2_d = pin_s1_q;
        pin_s3_d = pin_s2_q;
        pin_lvl_d = pin_lvl_q;
        for (int i = 0; i < 2; i++)
        begin
            if (pin_s2_q[i] == pin_s3_q[i])
            begin
                pin_lvl_d[i] = pin_s3_q[i];
            end
        end
        pin_prev_d = pin_lvl_q;
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
            pin_s3_q <= 2'h3;
            pin_lvl_q <= 2'h3;
            pin_prev_q <= 2'h3;
        end
        else
        begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_s3_q <= pin_s3_d;
            pin_lvl_q <= pin_lvl_d;
            pin_prev_q <= pin_prev_d;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] flags_q, flags_d, mask_q, mask_d, ctrl_q, ctrl_d;
    logic [15:0] cmpa_q, cmpa_d, cmpb_q, cmpb_d, capt_q, capt_d;
    logic [15:0] wprev_q, wprev_d;
    logic [7:0] nprev_q, nprev_d;
    logic glob_q, glob_d;
    logic [1:0] pin_hit;
    logic [7:0] set_ev, clr_ev;
    logic wr;
    logic [1:0] sense [2];

    assign wr = psel && penable && pwrite;
    assign sense[0] = ctrl_q[tiw_pkg::CTL_SENSE0 +: 2];
    assign sense[1] = ctrl_q[tiw_pkg::CTL_SENSE1 +: 2];

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_pin
            logic hit;
            always_comb
            begin
                unique case (sense[g])
                    tiw_pkg::SENSE_LOW: hit = !pin_lvl_q[g];
                    tiw_pkg::SENSE_FALL: hit = pin_prev_q[g] && !pin_lvl_q[g];
                    tiw_pkg::SENSE_RISE: hit = !pin_prev_q[g] && pin_lvl_q[g];
                    tiw_pkg::SENSE_RSVD: hit = 1'b0;
                endcase
            end
            assign pin_hit[g] = hit;
        end
    endgenerate

    always_comb
    begin
        set_ev = 8'h00;
        set_ev[tiw_pkg::BIT_CAPT] = capture_strobe;
        set_ev[tiw_pkg::BIT_CMPA] = (wide_count == cmpa_q) && (wprev_q != cmpa_q);
        set_ev[tiw_pkg::BIT_CMPB] = (wide_count == cmpb_q) && (wprev_q != cmpb_q);
        if (ctrl_q[tiw_pkg::CTL_UPDOWN])
        begin
            // up/down: flag as the count leaves zero while counting up
            set_ev[tiw_pkg::BIT_WOVF] = (wprev_q == tiw_pkg::CNT_ZERO)
                && (wide_count != tiw_pkg::CNT_ZERO) && !updown_dir;
        end
        else
        begin
            set_ev[tiw_pkg::BIT_WOVF] = (wprev_q == tiw_pkg::CNT_MAX)
                && (wide_count == tiw_pkg::CNT_ZERO);
        end
        set_ev[tiw_pkg::BIT_NOVF] = (nprev_q == tiw_pkg::NCNT_MAX)
            && (narrow_count == 8'h00);
        clr_ev = vector_ack & tiw_pkg::FLAG_MASK;
        if (wr && paddr == tiw_pkg::ADDR_FLAGS)
        begin
            clr_ev = clr_ev | (pwdata[7:0] & tiw_pkg::FLAG_MASK);
        end
        // set wins over a clear in the same cycle; bit one never stored
        flags_d = ((flags_q & ~clr_ev) | set_ev) & tiw_pkg::FLAG_MASK;
        capt_d = capture_strobe ? wide_count : capt_q;
        wprev_d = wide_count;
        nprev_d = narrow_count;
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        cmpa_d = cmpa_q;
        cmpb_d = cmpb_q;
        glob_d = glob_q;
        if (wr)
        begin
            unique case (paddr)
                tiw_pkg::ADDR_MASK: mask_d = pwdata[7:0];
                tiw_pkg::ADDR_CTRL: ctrl_d = pwdata[7:0];
                tiw_pkg::ADDR_CMPA: cmpa_d = pwdata[15:0];
                tiw_pkg::ADDR_CMPB: cmpb_d = pwdata[15:0];
                tiw_pkg::ADDR_GLOB: glob_d = pwdata[0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sleep state
    // ------------------------------------------------------------
    tiw_pkg::tiw_state_t st_q, st_d;
    logic [1:0] mode_q, mode_d;
    logic [7:0] req_d;
    logic wake_any, wake_d;
    logic [31:0] rdata_d;
    logic err_d;

    always_comb
    begin
        // requests need global, own enable and flag (or pin hit)
        req_d = 8'h00;
        req_d[5:0] = glob_q ? (flags_q[5:0] & mask_q[5:0]) : 6'h00;
        req_d[tiw_pkg::BIT_PIN0_EN] = glob_q && mask_q[tiw_pkg::BIT_PIN0_EN]
            && pin_hit[0];
        req_d[tiw_pkg::BIT_PIN1_EN] = glob_q && mask_q[tiw_pkg::BIT_PIN1_EN]
            && pin_hit[1];
        // power-down and save only wake on a low-level pin request
        if (mode_q == tiw_pkg::SMODE_IDLE)
        begin
            wake_any = |req_d;
        end
        else
        begin
            wake_any = (req_d[tiw_pkg::BIT_PIN0_EN] && sense[0] == tiw_pkg::SENSE_LOW)
                || (req_d[tiw_pkg::BIT_PIN1_EN] && sense[1] == tiw_pkg::SENSE_LOW);
        end
        st_d = st_q;
        mode_d = mode_q;
        wake_d = 1'b0;
        unique case (st_q)
            tiw_pkg::TIW_RUN:
            begin
                if (sleep_exec && ctrl_q[tiw_pkg::CTL_SLEEP_EN]
                    && ctrl_q[tiw_pkg::CTL_SMODE +: 2] != 2'h1)
                begin
                    st_d = tiw_pkg::TIW_SLEEP;
                    mode_d = ctrl_q[tiw_pkg::CTL_SMODE +: 2];
                end
            end
            tiw_pkg::TIW_SLEEP:
            begin
                if (wake_any)
                begin
                    st_d = tiw_pkg::TIW_WAKE;
                    wake_d = 1'b1;
                end
            end
            tiw_pkg::TIW_WAKE:
            begin
                st_d = tiw_pkg::TIW_RUN;
            end
            default: st_d = tiw_pkg::TIW_RUN;
        endcase
        rdata_d = 32'h00000000;
        err_d = 1'b0;
        if (psel && !penable)
        begin
            unique case (paddr)
                tiw_pkg::ADDR_FLAGS: rdata_d[7:0] = flags_q;
                tiw_pkg::ADDR_MASK: rdata_d[7:0] = mask_q;
                tiw_pkg::ADDR_CTRL: rdata_d[7:0] = ctrl_q;
                tiw_pkg::ADDR_CMPA: rdata_d[15:0] = cmpa_q;
                tiw_pkg::ADDR_CMPB: rdata_d[15:0] = cmpb_q;
                tiw_pkg::ADDR_CAPT: rdata_d[15:0] = capt_q;
                tiw_pkg::ADDR_STAT: rdata_d[4:0] = {mode_q, st_q};
                tiw_pkg::ADDR_GLOB: rdata_d[0] = glob_q;
                default: err_d = 1'b1;
            endcase
        end
    end

    // registers hold across sleep: entering and leaving sleep changes none of them
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            flags_q <= 8'h00;
            mask_q <= 8'h00;
            ctrl_q <= tiw_pkg::CTRL_RST;
            cmpa_q <= 16'h0000;
            cmpb_q <= 16'h0000;
            capt_q <= 16'h0000;
            wprev_q <= 16'h0000;
            nprev_q <= 8'h00;
            glob_q <= 1'b0;
            st_q <= tiw_pkg::TIW_RUN;
            mode_q <= tiw_pkg::SMODE_IDLE;
            irq_req <= 8'h00;
            wake_pulse <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            ctrl_q <= ctrl_d;
            cmpa_q <= cmpa_d;
            cmpb_q <= cmpb_d;
            capt_q <= capt_d;
            wprev_q <= wprev_d;
            nprev_q <= nprev_d;
            glob_q <= glob_d;
            st_q <= st_d;
            mode_q <= mode_d;
            irq_req <= req_d;
            wake_pulse <= wake_d;
            prdata <= rdata_d;
            pready <= psel && !penable;
            pslverr <= err_d;
        end
    end

    assign core_sleep = st_q[1];
    assign sleep_mode = mode_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_capt_set: assert property (capture_strobe |=> flags_q[tiw_pkg::BIT_CAPT])
        else $error("capture flag not set");
    chk_flag_clear: assert property (flags_q[tiw_pkg::BIT_CMPA] && vector_ack[tiw_pkg::BIT_CMPA]
        && !set_ev[tiw_pkg::BIT_CMPA] |=> !flags_q[tiw_pkg::BIT_CMPA])
        else $error("vector did not clear flag");
    chk_req_gate: assert property (!glob_q |=> irq_req == 8'h00)
        else $error("request without global enable");
    chk_cmpa_set: assert property (set_ev[tiw_pkg::BIT_CMPA] |=> flags_q[tiw_pkg::BIT_CMPA])
        else $error("compare a flag missed");
    chk_cmpb_set: assert property (wide_count == cmpb_q && wprev_q != cmpb_q
        |=> flags_q[tiw_pkg::BIT_CMPB])
        else $error("compare b flag missed");
    chk_wovf_set: assert property (!ctrl_q[tiw_pkg::CTL_UPDOWN] && wprev_q == tiw_pkg::CNT_MAX
        && wide_count == tiw_pkg::CNT_ZERO |=> flags_q[tiw_pkg::BIT_WOVF])
        else $error("wide overflow missed");
    chk_rsvd_zero: assert property (!flags_q[tiw_pkg::BIT_RSVD])
        else $error("reserved bit set");
    chk_sleep_gate: assert property (st_q == tiw_pkg::TIW_RUN
        && !ctrl_q[tiw_pkg::CTL_SLEEP_EN] |=> st_q == tiw_pkg::TIW_RUN)
        else $error("sleep without enable");
    chk_rsvd_sense: assert property (sense[0] == tiw_pkg::SENSE_RSVD
        |=> !irq_req[tiw_pkg::BIT_PIN0_EN])
        else $error("reserved sense requested");
    chk_wake_run: assert property (wake_pulse |=> st_q == tiw_pkg::TIW_RUN)
        else $error("wake did not resume");
    cov_sleep: cover property (st_q == tiw_pkg::TIW_SLEEP ##[1:50] wake_pulse);
    cov_pin_low: cover property (irq_req[tiw_pkg::BIT_PIN0_EN] [*3]);
    cov_set_clr: cover property (set_ev[tiw_pkg::BIT_CAPT] && clr_ev[tiw_pkg::BIT_CAPT]);
endmodule : tiw_irq_wake

/* File: tiw_irq_wake_tb.sv */
// Purpose: self-checking bench for the irq/wake block
// Assumes: zero-wait APB slave; pins pass a synchroniser
// Notes: reads queue their expected word, a monitor compares
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module tiw_irq_wake_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic capture_strobe = 1'b0, updown_dir = 1'b0;
    logic [7:0] paddr = 8'h00, narrow_count = 8'h00;
    logic [15:0] wide_count = 16'h0000, cv;
    logic [31:0] pwdata = 32'h0, prdata, cw, seed = 32'h0001_0067;
    logic pready, pslverr, ext_irq_pin_zero, ext_irq_pin_one, sleep_exec, core_sleep, wake_pulse;
    logic [7:0] vector_ack, irq_req;
    logic [1:0] sleep_mode, m;
    logic [31:0] exp_q[$];
    logic [31:0] exp_w;
    int errors = 0, cmp_count = 0, cycles = 0;

    tiw_irq_wake tiw_irq_wake_inst (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .wide_count, .narrow_count, .capture_strobe,
        .updown_dir, .ext_irq_pin_zero, .ext_irq_pin_one, .vector_ack, .sleep_exec,
        .irq_req, .core_sleep, .sleep_mode, .wake_pulse);
    tiw_far_side tiw_far_side_inst (.clk_sys, .ext_irq_pin_zero, .ext_irq_pin_one,
        .vector_ack, .sleep_exec);

    always #20 clk_sys = ~clk_sys;

    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // generous ceiling: the sequence needs about six hundred cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            `CHK(pslverr, paddr > 8'h1C)
            // pop once: the macro names its expected value twice
            if (exp_q.size() == 0)
            begin
                errors++;
            end
            else
            begin
                exp_w = exp_q.pop_front();
                `CHK(prdata, exp_w)
            end
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // skip s edges so a stale registered value is not counted, then look 10 cycles
    task automatic watch(input int b, input logic e, input int s);
        logic h;
        h = 1'b0;
        tick(s);
        repeat (10)
        begin
            @(posedge clk_sys);
            h = h | (b == 8 ? wake_pulse : irq_req[b]);
        end
        `CHK(h, e)
    endtask : watch

    task automatic cap(input logic [15:0] v);
        wide_count <= v;
        capture_strobe <= 1'b1;
        tick(1);
        capture_strobe <= 1'b0;
    endtask : cap

    task automatic ev(input logic [15:0] w0, w1, input logic [7:0] n0, n1,
        input logic [31:0] e);
        wide_count <= w0;
        narrow_count <= n0;
        tick(2);
        wr(tiw_pkg::ADDR_FLAGS, 32'h3D);
        wide_count <= w1;
        narrow_count <= n1;
        tick(2);
        rd(tiw_pkg::ADDR_FLAGS, e);
    endtask : ev

    initial
    begin
        tick(10);
        nrst <= 1'b1;
        rd(tiw_pkg::ADDR_FLAGS, 32'h0);
        rd(tiw_pkg::ADDR_CTRL, {24'h0, tiw_pkg::CTRL_RST});
        rd(8'h20, 32'h0);
        wr(tiw_pkg::ADDR_FLAGS, 32'hFF);
        rd(tiw_pkg::ADDR_FLAGS, 32'h0);
        cv = 16'(rnd());
        cap(cv);
        rd(tiw_pkg::ADDR_FLAGS, 32'h20);
        rd(tiw_pkg::ADDR_CAPT, {16'h0, cv});
        wr(tiw_pkg::ADDR_FLAGS, 32'h0);
        rd(tiw_pkg::ADDR_FLAGS, 32'h20);
        wr(tiw_pkg::ADDR_MASK, 32'h20);
        watch(5, 1'b0, 1);
        wr(tiw_pkg::ADDR_GLOB, 32'h1);
        watch(5, 1'b1, 1);
        tiw_far_side_inst.ack(5);
        watch(5, 1'b0, 1);
        cv = (16'(rnd()) & 16'h7FFF) | 16'h0002;
        wr(tiw_pkg::ADDR_CMPA, {16'h0, cv});
        wr(tiw_pkg::ADDR_CMPB, {16'h0, ~cv});
        ev(cv - 16'h1, cv, 8'h10, 8'h10, 32'h10);
        ev(~cv - 16'h1, ~cv, 8'h10, 8'h10, 32'h08);
        ev(16'hFFFF, 16'h0000, 8'h10, 8'h10, 32'h04);
        ev(16'h1000, 16'h1000, 8'hFF, 8'h00, 32'h01);
        wr(tiw_pkg::ADDR_MASK, 32'h01);
        watch(0, 1'b1, 1);
        tiw_far_side_inst.ack(0);
        rd(tiw_pkg::ADDR_FLAGS, 32'h0);
        wr(tiw_pkg::ADDR_CTRL, 32'h80);
        ev(16'h0000, 16'h0001, 8'h10, 8'h10, 32'h04);
        ev(16'hFFFF, 16'h0000, 8'h10, 8'h10, 32'h00);
        wr(tiw_pkg::ADDR_CTRL, 32'h0);
        wr(tiw_pkg::ADDR_FLAGS, 32'h04);
        rd(tiw_pkg::ADDR_FLAGS, 32'h0);
        wr(tiw_pkg::ADDR_MASK, 32'hC0);
        for (int k = 0; k < 2; k++)
            for (int c = 0; c < 4; c++)
            begin
                wr(tiw_pkg::ADDR_CTRL, 32'(c << (2 * k)));
                tiw_far_side_inst.pin(k, 1'b0);
                watch(6 + k, c == 0 || c == 2, 1);
                if (c == 0) `CHK(irq_req[6 + k], 1'b1)
                tiw_far_side_inst.pin(k, 1'b1);
                watch(6 + k, c == 3, c == 0 ? 6 : 1);
            end
        wr(tiw_pkg::ADDR_CTRL, 32'h0);
        wr(tiw_pkg::ADDR_MASK, 32'h80);
        tiw_far_side_inst.pin(0, 1'b0);
        watch(6, 1'b0, 1);
        tiw_far_side_inst.pin(0, 1'b1);
        wr(tiw_pkg::ADDR_CTRL, 32'h30);
        tiw_far_side_inst.sleep_cmd();
        tick(2);
        `CHK(core_sleep, 1'b0)
        for (int i = 0; i < 3; i++)
        begin
            m = 2'(i == 0 ? 0 : i + 1);
            cw = {24'h0, 2'b01, m, 4'h0};
            wr(tiw_pkg::ADDR_FLAGS, 32'h3D);
            wr(tiw_pkg::ADDR_MASK, 32'h60);
            wr(tiw_pkg::ADDR_CTRL, cw);
            tiw_far_side_inst.sleep_cmd();
            tick(2);
            `CHK(core_sleep, 1'b1)
            `CHK(sleep_mode, m)
            cap(16'h0);
            watch(8, m == 2'h0, 1);
            if (m != 2'h0)
            begin
                tiw_far_side_inst.pin(0, 1'b0);
                watch(8, 1'b1, 1);
                tiw_far_side_inst.pin(0, 1'b1);
                tick(8);
            end
            `CHK(core_sleep, 1'b0)
            rd(tiw_pkg::ADDR_CTRL, cw);
        end
        wr(tiw_pkg::ADDR_FLAGS, 32'h3D);
        wr(tiw_pkg::ADDR_CTRL, 32'h60);
        tiw_far_side_inst.sleep_cmd();
        tick(2);
        `CHK(core_sleep, 1'b1)
        `CHK(sleep_mode, tiw_pkg::SMODE_PDOWN)
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(1);
        `CHK(core_sleep, 1'b0)
        `CHK(sleep_mode, tiw_pkg::SMODE_IDLE)
        rd(tiw_pkg::ADDR_CTRL, 32'h0);
        give_verdict();
    end
endmodule : tiw_irq_wake_tb

/* File: tiw_pkg.sv */
// Purpose: constants for the timer flag, external interrupt and sleep/wake block
// Assumes: 25 MHz clk_sys, APB slave with 32-bit data
// Notes: register offsets are byte addresses
package tiw_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CMPA = 8'h0C;
    localparam logic [7:0] ADDR_CMPB = 8'h10;
    localparam logic [7:0] ADDR_CAPT = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_GLOB = 8'h1C;
    // ------------------------------------------------------------
    // flag bits
    // ------------------------------------------------------------
    localparam int BIT_CAPT = 5;
    localparam int BIT_CMPA = 4;
    localparam int BIT_CMPB = 3;
    localparam int BIT_WOVF = 2;
    localparam int BIT_RSVD = 1;
    localparam int BIT_NOVF = 0;
    localparam logic [7:0] FLAG_MASK = 8'h3D;
    // mask register: timer enables in flag positions, pin masks above
    localparam int BIT_PIN0_EN = 6;
    localparam int BIT_PIN1_EN = 7;
    // control register fields
    localparam int CTL_SENSE0 = 0;
    localparam int CTL_SENSE1 = 2;
    localparam int CTL_SMODE = 4;
    localparam int CTL_SLEEP_EN = 6;
    localparam int CTL_UPDOWN = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_RSVD = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    localparam logic [1:0] SMODE_IDLE = 2'h0;
    localparam logic [1:0] SMODE_PDOWN = 2'h2;
    localparam logic [1:0] SMODE_SAVE = 2'h3;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] NCNT_MAX = 8'hFF;

    typedef enum logic [2:0] {
        TIW_RUN = 3'b001,
        TIW_SLEEP = 3'b010,
        TIW_WAKE = 3'b100
    } tiw_state_t;
endpackage : tiw_pkg
